// [src/dppa_pkg.sv]
// Constants shared by the dual port peripheral adapter and its side logic.
// Assumes one synchronous clock standing in for the phase-two clock.
package dppa_pkg;

    // Register addresses on the two register-select lines
    localparam logic [1:0] ADDR_DATA_A = 2'h0;
    localparam logic [1:0] ADDR_CTL_A = 2'h1;
    localparam logic [1:0] ADDR_DATA_B = 2'h2;
    localparam logic [1:0] ADDR_CTL_B = 2'h3;

    // Control register field positions
    localparam int CTL_FLAG1_BIT = 7;
    localparam int CTL_FLAG2_BIT = 6;
    localparam int CTL_MODE2_HI = 5;
    localparam int CTL_MODE2_LO = 3;
    localparam int CTL_SEL_BIT = 2;
    localparam int CTL_MODE1_HI = 1;
    localparam int CTL_MODE1_LO = 0;
    // Meaning of the mode bits inside those fields
    localparam int CTL_EN1_BIT = 0;
    localparam int CTL_EDGE1_BIT = 1;
    localparam int CTL_EN2_BIT = 3;
    localparam int CTL_EDGE2_BIT = 4;
    localparam int CTL_OUT2_BIT = 5;

    // Reset values of the control, direction, output and holding registers
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_BUF = 8'h00;

    // Cycles from the write capture to the register update
    localparam int WR_COMMIT_CYCLES = 1;

endpackage : dppa_pkg

// [src/dppa_side_if.sv]
// Link between the register decoder and one side's logic.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dppa_side_if;
    logic [7:0] wr_data; // Held write data
    logic wr_ctl; // Pulse: commit control register
    logic wr_dir; // Pulse: commit direction register
    logic wr_out; // Pulse: commit output register
    logic rd_port; // Pulse: port read, clears flags
    logic [7:0] ctl; // Control register image
    logic [7:0] dir; // Direction register
    logic [7:0] pout; // Output register
    logic irq_oe; // Request line pulled low
    logic c2_out; // Second control line drive level
    logic c2_oe; // Second control line driven

    // Decoder end
    modport decoder (output wr_data, wr_ctl, wr_dir, wr_out, rd_port,
                     input ctl, dir, pout, irq_oe, c2_out, c2_oe);
    // Side end
    modport side (input wr_data, wr_ctl, wr_dir, wr_out, rd_port,
                  output ctl, dir, pout, irq_oe, c2_out, c2_oe);
endinterface : dppa_side_if
`default_nettype wire

// [src/dppa_side.sv]
// One side of the adapter: control, direction and output registers,
// control line synchronisers, edge detection and interrupt request.
// Assumes write pulses come from the decoder one cycle after capture.
`timescale 1ns/1ps
`default_nettype none
module dppa_side
    import dppa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Peripheral control lines
    input wire logic ctl_in1,
    input wire logic ctl_in2,
    // Decoder link
    dppa_side_if.side lnk
);

    logic [2:0] sync1; // Line one: two sync stages and previous value
    logic [2:0] sync2; // Line two: two sync stages and previous value
    logic flag1; // Status flag of line one
    logic flag2; // Status flag of line two
    logic [5:0] mode; // Writable control bits 5..0
    logic [7:0] dir; // Direction register
    logic [7:0] pout; // Output register
    logic irq_oe; // Registered request
    logic c2_out; // Registered drive level of line two
    logic c2_oe; // Registered drive enable of line two
    logic edge1; // Active transition on line one
    logic edge2; // Active transition on line two

    // Synchronise control inputs; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge reset_n) begin // see R18
        if (!reset_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {sync1[1:0], ctl_in1};
            sync2 <= {sync2[1:0], ctl_in2};
        end
    end

    // Edge polarity chosen by the mode bits; line two only as input
    always_comb begin // see R10
        edge1 = mode[CTL_EDGE1_BIT] ? (sync1[1] & ~sync1[2])
                                    : (~sync1[1] & sync1[2]);
        edge2 = ~mode[CTL_OUT2_BIT] &
                (mode[CTL_EDGE2_BIT] ? (sync2[1] & ~sync2[2])
                                     : (~sync2[1] & sync2[2]));
    end

    // Status flags: set by edges, cleared by port read, set wins
    always_ff @(posedge clk or negedge reset_n) begin // see R11
        if (!reset_n) begin
            flag1 <= RST_CTL[CTL_FLAG1_BIT];
            flag2 <= RST_CTL[CTL_FLAG2_BIT];
        end else begin
            flag1 <= edge1 | (flag1 & ~lnk.rd_port); // see R17
            flag2 <= edge2 | (flag2 & ~lnk.rd_port); // see R17
        end
    end

    // Writable control bits; flags stay read only
    always_ff @(posedge clk or negedge reset_n) begin // see R15
        if (!reset_n) begin
            mode <= RST_CTL[5:0];
        end else if (lnk.wr_ctl) begin // see R12
            mode <= lnk.wr_data[5:0];
        end
    end

    // Direction and output registers
    always_ff @(posedge clk or negedge reset_n) begin // see R15
        if (!reset_n) begin
            dir <= RST_DIR;
            pout <= RST_OUT;
        end else begin
            if (lnk.wr_dir) begin
                dir <= lnk.wr_data; // see R06
            end
            if (lnk.wr_out) begin
                pout <= lnk.wr_data; // see R07
            end
        end
    end

    // Request and second-line drive, registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_oe <= 1'b0;
            c2_out <= 1'b0;
            c2_oe <= 1'b0;
        end else begin
            irq_oe <= (flag1 & mode[CTL_EN1_BIT]) |
                      (flag2 & mode[CTL_EN2_BIT]); // see R16
            c2_out <= mode[CTL_EN2_BIT]; // see R12
            c2_oe <= mode[CTL_OUT2_BIT]; // see R12
        end
    end

    // Images back to the decoder
    assign lnk.ctl = {flag1, flag2, mode}; // see R11
    assign lnk.dir = dir;
    assign lnk.pout = pout;
    assign lnk.irq_oe = irq_oe;
    assign lnk.c2_out = c2_out;
    assign lnk.c2_oe = c2_oe;

endmodule : dppa_side
`default_nettype wire

// [src/dppa_top.sv]
// Dual port peripheral adapter: processor bus slave, write holding
// register, register decode and two independent port sides.
// Assumes bus inputs and peripheral lines are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: Capture write data, commit one cycle later
// R02: Two independent sides, each full register set
// R03: Control bit 2 selects output or direction
// R04: Decode register from selects and bit 2
// R05: Processor sets bit 2 before data access
// R06: Direction bit one output, zero input
// R07: Output register bit drives port A line
// R08: Port B output register works like A
// R09: Port read returns present pin levels
// R10: Status logic detects control line transitions
// R11: Bits 7 and 6 hold line flags
// R12: Mode fields bits 5..3 and 1..0
// R13: Port B behaves like port A
// R14: Addresses 0..3 map data A, ctl A, data B, ctl B
// R15: Reset clears every internal register
// R16: Request low on flag with its enable
// R17: Port read clears both flags of side
// R18: Synchronise control inputs before edge detection
module dppa_top
    import dppa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Processor bus
    input wire logic chip_sel0,
    input wire logic chip_sel1,
    input wire logic chip_sel2_n,
    input wire logic rw,
    input wire logic reg_sel_lo,
    input wire logic reg_sel_hi,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Interrupt requests, open drain
    input wire logic irq_out_a_n_in,
    output logic irq_out_a_n_out,
    output logic irq_out_a_n_oe,
    input wire logic irq_out_b_n_in,
    output logic irq_out_b_n_out,
    output logic irq_out_b_n_oe,
    // Port A lines
    input wire logic [7:0] port_a_lines_in,
    output logic [7:0] port_a_lines_out,
    output logic [7:0] port_a_lines_oe,
    // Port B lines
    input wire logic [7:0] port_b_lines_in,
    output logic [7:0] port_b_lines_out,
    output logic [7:0] port_b_lines_oe,
    // Side A control lines
    input wire logic ctl_in_a1,
    input wire logic ctl_io_a2_in,
    output logic ctl_io_a2_out,
    output logic ctl_io_a2_oe,
    // Side B control lines
    input wire logic ctl_in_b1,
    input wire logic ctl_io_b2_in,
    output logic ctl_io_b2_out,
    output logic ctl_io_b2_oe
);

    logic selected; // Chip select decode
    logic [1:0] addr; // Register address from select lines
    logic [7:0] bus_buffer; // Write holding register
    logic pend_wr; // Write waiting to commit
    logic [1:0] pend_addr; // Address of the waiting write
    logic [7:0] next_data_out; // Read data mux
    logic rd_a; // Read of port A this cycle
    logic rd_b; // Read of port B this cycle

    // One link per side
    dppa_side_if lnk_a ();
    dppa_side_if lnk_b ();

    // Bus decode
    assign selected = chip_sel0 & chip_sel1 & ~chip_sel2_n;
    assign addr = {reg_sel_hi, reg_sel_lo};

    // Capture write data during the access cycle
    always_ff @(posedge clk or negedge reset_n) begin // see R01
        if (!reset_n) begin
            bus_buffer <= RST_BUF;
            pend_wr <= 1'b0;
            pend_addr <= ADDR_DATA_A;
        end else begin
            pend_wr <= selected & ~rw;
            if (selected && !rw) begin
                bus_buffer <= data_in;
                pend_addr <= addr;
            end
        end
    end

    // Commit strobes: address, plus the side's select bit for the data registers
    always_comb begin // see R04
        lnk_a.wr_data = bus_buffer; // see R01
        lnk_b.wr_data = bus_buffer;
        lnk_a.wr_ctl = pend_wr & (pend_addr == ADDR_CTL_A); // see R14
        lnk_b.wr_ctl = pend_wr & (pend_addr == ADDR_CTL_B);
        // Bit 2 set picks the output register, clear the direction
        lnk_a.wr_out = pend_wr & (pend_addr == ADDR_DATA_A) &
                       lnk_a.ctl[CTL_SEL_BIT]; // see R03
        lnk_a.wr_dir = pend_wr & (pend_addr == ADDR_DATA_A) &
                       ~lnk_a.ctl[CTL_SEL_BIT]; // see R03
        lnk_b.wr_out = pend_wr & (pend_addr == ADDR_DATA_B) &
                       lnk_b.ctl[CTL_SEL_BIT]; // see R08
        lnk_b.wr_dir = pend_wr & (pend_addr == ADDR_DATA_B) &
                       ~lnk_b.ctl[CTL_SEL_BIT]; // see R13
    end

    // Port reads with bit 2 set clear that side's flags
    always_comb begin // see R17
        rd_a = selected & rw & (addr == ADDR_DATA_A) &
               lnk_a.ctl[CTL_SEL_BIT];
        rd_b = selected & rw & (addr == ADDR_DATA_B) &
               lnk_b.ctl[CTL_SEL_BIT];
        lnk_a.rd_port = rd_a;
        lnk_b.rd_port = rd_b;
    end

    // Read data selection
    always_comb begin // see R14
        unique case (addr)
            ADDR_DATA_A: begin
                // Pin levels or direction register
                next_data_out = lnk_a.ctl[CTL_SEL_BIT] ?
                                port_a_lines_in : lnk_a.dir; // see R09
            end
            ADDR_CTL_A: begin
                next_data_out = lnk_a.ctl;
            end
            ADDR_DATA_B: begin
                next_data_out = lnk_b.ctl[CTL_SEL_BIT] ?
                                port_b_lines_in : lnk_b.dir; // see R13
            end
            ADDR_CTL_B: begin
                next_data_out = lnk_b.ctl;
            end
        endcase
    end

    // Registered read answer and bus drive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_oe <= selected & rw;
            if (selected && rw) begin
                data_out <= next_data_out;
            end
        end
    end

    // Side A logic
    dppa_side side_a (
        .clk(clk),
        .reset_n(reset_n),
        .ctl_in1(ctl_in_a1),
        .ctl_in2(ctl_io_a2_in),
        .lnk(lnk_a.side)
    ); // see R02

    // Side B logic
    dppa_side side_b (
        .clk(clk),
        .reset_n(reset_n),
        .ctl_in1(ctl_in_b1),
        .ctl_in2(ctl_io_b2_in),
        .lnk(lnk_b.side)
    ); // see R02

    // Port lines straight from side registers
    assign port_a_lines_out = lnk_a.pout; // see R07
    assign port_a_lines_oe = lnk_a.dir; // see R06
    assign port_b_lines_out = lnk_b.pout; // see R08
    assign port_b_lines_oe = lnk_b.dir; // see R13

    // Open-drain requests: drive low while pulled
    assign irq_out_a_n_out = 1'b0;
    assign irq_out_a_n_oe = lnk_a.irq_oe; // see R16
    assign irq_out_b_n_out = 1'b0;
    assign irq_out_b_n_oe = lnk_b.irq_oe; // see R16

    // Second control lines in output mode
    assign ctl_io_a2_out = lnk_a.c2_out;
    assign ctl_io_a2_oe = lnk_a.c2_oe;
    assign ctl_io_b2_out = lnk_b.c2_out;
    assign ctl_io_b2_oe = lnk_b.c2_oe;

endmodule : dppa_top
`default_nettype wire

// [testbench/dppa_props.sv]
// Checker on the adapter's top ports: bus answers and port updates.
// Assumes it is bound to dppa_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module dppa_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Processor bus
    input wire logic chip_sel0,
    input wire logic chip_sel1,
    input wire logic chip_sel2_n,
    input wire logic rw,
    input wire logic reg_sel_lo,
    input wire logic reg_sel_hi,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    // Port and control outputs, port A pin levels
    input wire logic irq_out_a_n_out,
    input wire logic irq_out_a_n_oe,
    input wire logic [7:0] port_a_lines_in,
    input wire logic [7:0] port_a_lines_out,
    input wire logic [7:0] port_a_lines_oe,
    input wire logic [7:0] port_b_lines_out,
    input wire logic [7:0] port_b_lines_oe,
    input wire logic ctl_io_a2_oe
);
    logic sel; // Device selected this cycle
    logic [1:0] adr; // Register address
    assign sel = chip_sel0 & chip_sel1 & ~chip_sel2_n;
    assign adr = {reg_sel_hi, reg_sel_lo};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RD_OE: assert property (sel && rw |=> data_oe)
        else $error("read not answered");
    AST_NO_OE: assert property (!(sel && rw) |=> !data_oe)
        else $error("data driven without read");
    AST_WR_A: assert property (sel && !rw && adr == 2'h0 |-> ##2
        (port_a_lines_oe == $past(data_in, 2) ||
         port_a_lines_out == $past(data_in, 2)))
        else $error("side A data write lost");
    AST_WR_B: assert property (sel && !rw && adr == 2'h2 |-> ##2
        (port_b_lines_oe == $past(data_in, 2) ||
         port_b_lines_out == $past(data_in, 2)))
        else $error("side B data write lost");
    AST_OE_A: assert property ($changed(port_a_lines_oe) |->
        $past(sel && !rw && adr == 2'h0, 2))
        else $error("direction A changed without write");
    AST_OUT_A: assert property ($changed(port_a_lines_out) |->
        $past(sel && !rw && adr == 2'h0, 2))
        else $error("output A changed without write");
    AST_OUT_B: assert property ($changed(port_b_lines_out) |->
        $past(sel && !rw && adr == 2'h2, 2))
        else $error("output B changed without write");
    AST_RD_A: assert property (sel && rw && adr == 2'h0 |=>
        (data_out == $past(port_a_lines_in) || data_out == port_a_lines_oe))
        else $error("port A read wrong");
    AST_IRQ_LOW: assert property (sel && rw && adr == 2'h1 |=>
        irq_out_a_n_out == 1'b0 &&
        irq_out_a_n_oe == ((data_out[7] & data_out[0]) |
                           (data_out[6] & data_out[3])))
        else $error("request A disagrees with control flags");
    AST_C2: assert property ($changed(ctl_io_a2_oe) |->
        $past(sel && !rw && adr == 2'h1, 2) ||
        $past(sel && !rw && adr == 2'h1, 3))
        else $error("line two enable changed without write");
endmodule : dppa_props
bind dppa_top dppa_props u_props (.clk(clk), .reset_n(reset_n),
    .chip_sel0(chip_sel0), .chip_sel1(chip_sel1),
    .chip_sel2_n(chip_sel2_n), .rw(rw), .reg_sel_lo(reg_sel_lo),
    .reg_sel_hi(reg_sel_hi), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .irq_out_a_n_out(irq_out_a_n_out),
    .irq_out_a_n_oe(irq_out_a_n_oe),
    .port_a_lines_in(port_a_lines_in), .port_a_lines_out(port_a_lines_out),
    .port_a_lines_oe(port_a_lines_oe), .port_b_lines_out(port_b_lines_out),
    .port_b_lines_oe(port_b_lines_oe), .ctl_io_a2_oe(ctl_io_a2_oe));
`default_nettype wire

// [testbench/dppa_far.sv]
// Peripheral side model: resolves port and control line levels.
// Assumes port A has pull-ups and port B floats when nobody drives.
`timescale 1ns/1ps
`default_nettype none
module dppa_far (
    // Design drive
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic c2a_out,
    input wire logic c2a_oe,
    input wire logic c2b_out,
    input wire logic c2b_oe,
    // Peripheral drive
    input wire logic per_en,
    input wire logic [7:0] a_drv,
    input wire logic [7:0] b_drv,
    input wire logic c2a_drv,
    input wire logic c2b_drv,
    // Resolved pin levels
    output logic [7:0] a_pins,
    output logic [7:0] b_pins,
    output logic c2a_pin,
    output logic c2b_pin
);
    logic [7:0] a_idle; // Pull-up level or peripheral value
    logic [7:0] b_idle; // Floating B shows the inverse of the output register
    assign a_idle = per_en ? a_drv : 8'hFF;
    assign b_idle = per_en ? b_drv : ~b_out;
    assign a_pins = (a_oe & a_out) | (~a_oe & a_idle);
    assign b_pins = (b_oe & b_out) | (~b_oe & b_idle);
    assign c2a_pin = c2a_oe ? c2a_out : c2a_drv;
    assign c2b_pin = c2b_oe ? c2b_out : c2b_drv;
endmodule : dppa_far
`default_nettype wire

// [testbench/tb_dual_port_peripheral_adapter.sv]
// Self-checking bench: register accesses, port levels, flags, reset.
// Assumes dppa_top, its package and the far side model are compiled.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dual_port_peripheral_adapter;
    import dppa_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, chip_sel0 = 1'b0, chip_sel2_n = 1'b0;
    logic rw = 1'b1, rs_lo = 1'b0, rs_hi = 1'b0, data_oe, a2_out, a2_oe;
    logic b2_out, b2_oe, irq_a, irq_b, a1 = 1'b0, b1 = 1'b0, per_en = 1'b1;
    logic c2a_drv = 1'b0, c2b_drv = 1'b0, c2a_pin, c2b_pin;
    logic irq_ao, irq_bo; // Open-drain request drive levels
    logic [7:0] data_in = 8'h00, data_out, a_in, a_out, a_oe, b_in;
    logic [7:0] b_out, b_oe, a_drv = 8'h03, b_drv = 8'hA0;
    int errors = 0, samples_checked = 0;
    initial forever #2.5 clk = ~clk;
    dppa_top uut (.clk(clk), .reset_n(reset_n), .chip_sel0(chip_sel0),
        .chip_sel1(1'b1), .chip_sel2_n(chip_sel2_n), .rw(rw),
        .reg_sel_lo(rs_lo), .reg_sel_hi(rs_hi), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .irq_out_a_n_in(1'b1),
        .irq_out_a_n_out(irq_ao), .irq_out_a_n_oe(irq_a),
        .irq_out_b_n_in(1'b1), .irq_out_b_n_out(irq_bo),
        .irq_out_b_n_oe(irq_b), .port_a_lines_in(a_in),
        .port_a_lines_out(a_out), .port_a_lines_oe(a_oe),
        .port_b_lines_in(b_in), .port_b_lines_out(b_out),
        .port_b_lines_oe(b_oe), .ctl_in_a1(a1), .ctl_io_a2_in(c2a_pin),
        .ctl_io_a2_out(a2_out), .ctl_io_a2_oe(a2_oe), .ctl_in_b1(b1),
        .ctl_io_b2_in(c2b_pin), .ctl_io_b2_out(b2_out),
        .ctl_io_b2_oe(b2_oe));
    dppa_far far (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .c2a_out(a2_out), .c2a_oe(a2_oe), .c2b_out(b2_out), .c2b_oe(b2_oe),
        .per_en(per_en), .a_drv(a_drv), .b_drv(b_drv), .c2a_drv(c2a_drv),
        .c2b_drv(c2b_drv), .a_pins(a_in), .b_pins(b_in),
        .c2a_pin(c2a_pin), .c2b_pin(c2b_pin));
    // One bus access, then a gap cycle so a write has committed
    task automatic bus(input logic wr, input logic [1:0] a,
                       input logic [7:0] d, input logic dsel,
                       output logic [7:0] q);
        @(posedge clk);
        chip_sel0 <= 1'b1;
        chip_sel2_n <= dsel;
        rw <= ~wr;
        {rs_hi, rs_lo} <= a;
        data_in <= d;
        @(posedge clk);
        chip_sel0 <= 1'b0;
        rw <= 1'b1;
        #1 q = data_out;
        @(posedge clk);
        #1;
    endtask : bus
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 1'b0, q);
        `CHK(q, e)
    endtask : rd
    task automatic end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // Watchdog far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
        end_sim();
    end
    // Main sequence
    initial begin
        logic [7:0] q;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'hF0);
        wr(2'h2, 8'h0F);
        rd(2'h0, 8'hF0);
        rd(2'h2, 8'h0F);
        `CHK(a_oe, 8'hF0)
        `CHK(b_oe, 8'h0F)
        wr(2'h1, 8'h04);
        wr(2'h3, 8'h04);
        rd(2'h1, 8'h04);
        wr(2'h0, 8'hA5);
        wr(2'h2, 8'h5A);
        `CHK(a_out, 8'hA5)
        `CHK(b_out, 8'h5A)
        `CHK(a_oe, 8'hF0)
        `CHK(b_oe, 8'h0F)
        rd(2'h0, 8'hA3);
        rd(2'h2, 8'hAA);
        // Peripheral released: port A input lines sit at the pull-up level
        @(posedge clk) per_en <= 1'b0;
        rd(2'h0, 8'hAF);
        @(posedge clk) per_en <= 1'b1;
        wr(2'h1, 8'hC7);
        rd(2'h1, 8'h07);
        @(posedge clk) a1 <= 1'b1;
        repeat (6) @(posedge clk);
        rd(2'h1, 8'h87);
        `CHK(irq_a, 1'b1)
        rd(2'h0, 8'hA3);
        rd(2'h1, 8'h07);
        `CHK(irq_a, 1'b0)
        wr(2'h3, 8'h1C);
        @(posedge clk) c2b_drv <= 1'b1;
        repeat (6) @(posedge clk);
        rd(2'h3, 8'h5C);
        `CHK(irq_b, 1'b1)
        rd(2'h2, 8'hAA);
        rd(2'h3, 8'h1C);
        wr(2'h1, 8'h05);
        @(posedge clk) a1 <= 1'b0;
        repeat (6) @(posedge clk);
        rd(2'h1, 8'h85);
        wr(2'h1, 8'h2C);
        @(posedge clk);
        #1 `CHK({a2_oe, a2_out, irq_a}, 3'h6)
        wr(2'h3, 8'h24);
        @(posedge clk);
        #1 `CHK({b2_oe, b2_out, irq_b}, 3'h4)
        `CHK({irq_ao, irq_bo}, 2'h0)
        // Falling edge on side B line one sets its flag, request masked
        @(posedge clk) b1 <= 1'b1;
        repeat (6) @(posedge clk);
        b1 <= 1'b0;
        repeat (6) @(posedge clk);
        rd(2'h3, 8'hA4);
        `CHK(irq_b, 1'b0)
        bus(1'b1, 2'h1, 8'h00, 1'b1, q);
        rd(2'h1, 8'hAC);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1 `CHK({a_oe, b_out, a2_oe, b2_oe}, 18'h0)
        @(posedge clk) reset_n <= 1'b1;
        rd(2'h1, 8'h00);
        rd(2'h3, 8'h00);
        end_sim();
    end
endmodule : tb_dual_port_peripheral_adapter
`default_nettype wire
